// ---- logic/ufc_fifo_ctrl.sv ----
//
// Contract
// - Write-only FIFO control register at 0x8, effective on write.
// - Bits 7:6 set rx fill level raising data-available interrupt.
// - Auto flow control drops request-to-send by same trigger level.
// - Bit 3 picks DMA request mode unless extra handshake configured.
// - Mode 0 gives one character per request.
// - Mode 0 tx request low when holding reg or tx FIFO empty.
// - Mode 0 tx request released after one character written.
// - Mode 0 tx request released when tx fill above threshold.
// - Mode 1 request held for whole burst until FIFO full/empty.
// - Mode 1 tx request asserts when tx FIFO becomes empty.
// - Bit 2 resets tx FIFO, empties it, self-clears.
// - Bit 1 resets rx FIFO, empties it, self-clears.
// - Bit 0 enables FIFOs; any change resets and empties both.
//
`timescale 1ns/10ps
`default_nettype none
module ufc_fifo_ctrl (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic [7:0]                  i_addr,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [31:0]                 o_rdata,
  output logic                             o_irq,
  input  wire logic                        i_tx_wr,
  input  wire logic [ufc_pkg::DATA_W-1:0]  i_tx_data,
  input  wire logic                        i_tx_pop,
  output logic      [ufc_pkg::DATA_W-1:0]  o_tx_data,
  input  wire logic                        i_rx_push,
  input  wire logic [ufc_pkg::DATA_W-1:0]  i_rx_data,
  input  wire logic                        i_rx_rd,
  output logic      [ufc_pkg::DATA_W-1:0]  o_rx_data,
  output logic                             o_rts_n,
  output logic                             o_dma_tx_req_n,
  output logic                             o_dma_rx_req_n,
  output logic                             o_fifo_busy
);
  import ufc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                 fifo_en;
  logic                 dma_mode;
  logic [1:0]           rx_fill_trigger;
  logic                 tx_clear;
  logic                 rx_clear;
  logic [CNT_W-1:0]     tx_thresh;
  logic [1:0]           cfg;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  logic [3:0]           settle;
  logic                 tx_burst_q;
  ufc_burst_type        rx_state;
  logic                 tx_hold_full;
  logic [DATA_W-1:0]    tx_hold;
  logic [DATA_W-1:0]    rx_hold;
  logic                 rx_hold_full;
  logic                 rx_avail_q;
  logic                 tx_empty_q;
  logic                 rts_q;
  logic                 dma_tx_q;
  logic                 dma_rx_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_fc    = i_wr && (i_addr == FIFO_CONTROL_OFS);
  wire wr_stat  = i_wr && (i_addr == STATUS_OFS);
  wire wr_mask  = i_wr && (i_addr == MASK_OFS);
  wire wr_thr   = i_wr && (i_addr == TX_THRESH_OFS);
  wire wr_cfg   = i_wr && (i_addr == CFG_OFS);
  wire en_chg   = wr_fc && (i_wdata[FC_FIFO_EN] != fifo_en);
  wire next_tx_clear = (wr_fc && i_wdata[FC_TX_RESET]) || en_chg;
  wire next_rx_clear = (wr_fc && i_wdata[FC_RX_RESET]) || en_chg;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]  tx_count;
  logic [CNT_W-1:0]  rx_count;
  logic [DATA_W-1:0] tx_fifo_q;
  logic [DATA_W-1:0] rx_fifo_q;
  wire tx_full   = tx_count == CNT_W'(DEPTH);
  wire tx_empty  = fifo_en ? (tx_count == '0) : !tx_hold_full;
  wire rx_empty  = fifo_en ? (rx_count == '0) : !rx_hold_full;

  ufc_fifo_mem u_tx_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_clear    (tx_clear),
    .i_push     (fifo_en && i_tx_wr),
    .i_data     (i_tx_data),
    .i_pop      (fifo_en && i_tx_pop),
    .o_data     (tx_fifo_q),
    .o_count    (tx_count)
  );

  ufc_fifo_mem u_rx_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_clear    (rx_clear),
    .i_push     (fifo_en && i_rx_push),
    .i_data     (i_rx_data),
    .i_pop      (fifo_en && i_rx_rd),
    .o_data     (rx_fifo_q),
    .o_count    (rx_count)
  );

  assign o_tx_data = fifo_en ? tx_fifo_q : tx_hold;
  assign o_rx_data = fifo_en ? rx_fifo_q : rx_hold;

  // ----------------------------------------------------------------
  // Trigger level decode
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] trig_level;
  always_comb begin
    case (rx_fill_trigger)
      2'b00:   trig_level = TRIG_ONE;
      2'b01:   trig_level = TRIG_QUARTER;
      2'b10:   trig_level = TRIG_HALF;
      default: trig_level = TRIG_ALMOST;
    endcase
  end

  wire rx_trig_hit = fifo_en ? (rx_count >= trig_level) : rx_hold_full;
  wire rx_ovr      = !fifo_en && i_rx_push && rx_hold_full && !i_rx_rd;
  wire auto_fc     = cfg[CFG_AUTO_FC];
  wire ext_hs      = cfg[CFG_EXT_HS];
  // Extra handshake forces single signalling on both requests
  wire burst_mode  = dma_mode && !ext_hs;
  wire rx_req_hit  = burst_mode ? rx_trig_hit : !rx_empty;
  wire rx_one_rd   = !burst_mode && i_rx_rd;

  // ----------------------------------------------------------------
  // Control register and settings
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fifo_en         <= FC_RESET[FC_FIFO_EN];
      dma_mode        <= FC_RESET[FC_DMA_MODE];
      rx_fill_trigger <= FC_RESET[FC_TRIG_HI:FC_TRIG_LO];
      tx_clear        <= 1'b0;
      rx_clear        <= 1'b0;
      tx_thresh       <= TX_THRESH_RST;
      cfg             <= CFG_RESET;
      irq_mask        <= MASK_RESET;
    end else begin
      tx_clear <= next_tx_clear;
      rx_clear <= next_rx_clear;
      if (wr_fc) begin
        fifo_en         <= i_wdata[FC_FIFO_EN];
        dma_mode        <= i_wdata[FC_DMA_MODE];
        rx_fill_trigger <= i_wdata[FC_TRIG_HI:FC_TRIG_LO];
      end
      if (wr_thr) begin
        tx_thresh <= i_wdata[CNT_W-1:0];
      end
      if (wr_cfg) begin
        cfg <= i_wdata[1:0];
      end
      if (wr_mask) begin
        irq_mask <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Settling counter after reset or enable change
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      settle <= '0;
    end else if (next_tx_clear || next_rx_clear) begin
      settle <= SETTLE_CNT;
    end else if (settle != '0) begin
      settle <= settle - 4'h1;
    end
  end

  assign o_fifo_busy = settle != '0;

  // ----------------------------------------------------------------
  // Holding registers for non-FIFO mode
  // ----------------------------------------------------------------
  // Write wins over a pop in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst || tx_clear) begin
      tx_hold_full <= 1'b0;
      tx_hold      <= '0;
    end else if (!fifo_en && i_tx_wr) begin
      tx_hold_full <= 1'b1;
      tx_hold      <= i_tx_data;
    end else if (!fifo_en && i_tx_pop) begin
      tx_hold_full <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || rx_clear) begin
      rx_hold_full <= 1'b0;
      rx_hold      <= '0;
    end else if (!fifo_en && i_rx_push) begin
      rx_hold_full <= 1'b1;
      rx_hold      <= i_rx_data;
    end else if (!fifo_en && i_rx_rd) begin
      rx_hold_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit DMA request
  // ----------------------------------------------------------------
  wire tx_above  = fifo_en && (tx_count > tx_thresh);
  // Request is registered: the partner sees a drop one edge late
  wire tx_start  = tx_empty;
  wire tx_stop0  = i_tx_wr || tx_above;
  wire tx_stop1  = fifo_en ? (tx_full || (i_tx_wr && tx_count == CNT_W'(DEPTH - 1)))
                           : i_tx_wr;
  wire next_dma_tx = burst_mode
                   ? (tx_burst_q ? !tx_stop1 : (tx_start && !tx_stop1))
                   : (tx_start && !tx_stop0 && !dma_tx_q) ||
                     (dma_tx_q && !tx_stop0);

  always_ff @(posedge i_core_clk) begin
    if (i_rst || tx_clear) begin
      dma_tx_q   <= 1'b0;
      tx_burst_q <= 1'b0;
    end else begin
      dma_tx_q   <= next_dma_tx;
      tx_burst_q <= burst_mode && next_dma_tx;
    end
  end

  assign o_dma_tx_req_n = !dma_tx_q;

  // ----------------------------------------------------------------
  // Receive DMA request
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst || rx_clear) begin
      rx_state <= ST_IDLE;
      dma_rx_q <= 1'b0;
    end else begin
      case (rx_state)
        ST_IDLE: begin
          if (rx_req_hit) begin
            dma_rx_q <= 1'b1;
            rx_state <= burst_mode ? ST_BURST : ST_IDLE;
          end else begin
            dma_rx_q <= 1'b0;
          end
          if (rx_one_rd) begin
            dma_rx_q <= 1'b0;
          end
        end
        ST_BURST: begin
          if (rx_empty) begin
            dma_rx_q <= 1'b0;
            rx_state <= ST_IDLE;
          end
        end
        default: begin
          rx_state <= ST_IDLE;
          dma_rx_q <= 1'b0;
        end
      endcase
    end
  end

  assign o_dma_rx_req_n = !dma_rx_q;

  // ----------------------------------------------------------------
  // Auto flow control
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    // Idle level lets the far side send
    if (i_rst) begin
      rts_q <= 1'b1;
    end else begin
      rts_q <= !(auto_fc && rx_trig_hit);
    end
  end

  assign o_rts_n = !rts_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_RX_AVAIL] = rx_trig_hit && !rx_avail_q;
  assign irq_set[IRQ_TX_EMPTY] = tx_empty && !tx_empty_q;
  assign irq_set[IRQ_RX_OVR]   = rx_ovr;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_status <= '0;
      rx_avail_q <= 1'b0;
      tx_empty_q <= 1'b1;
    end else begin
      rx_avail_q <= rx_trig_hit;
      tx_empty_q <= tx_empty;
      irq_status <= (irq_status & ~(wr_stat ? i_wdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  assign o_irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped and write-only offsets read as zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      STATUS_OFS:    next_rdata = {29'h0, irq_status};
      MASK_OFS:      next_rdata = {29'h0, irq_mask};
      FILL_OFS:      next_rdata = {11'h0, rx_count, 11'h0, tx_count};
      TX_THRESH_OFS: next_rdata = {27'h0, tx_thresh};
      CFG_OFS:       next_rdata = {30'h0, cfg};
      default:       next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
    end
  end
endmodule : ufc_fifo_ctrl
`default_nettype wire

// ---- inc/ufc_pkg.sv ----
package ufc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FIFO_CONTROL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS       = 8'h10;
  localparam logic [7:0] MASK_OFS         = 8'h14;
  localparam logic [7:0] FILL_OFS         = 8'h18;
  localparam logic [7:0] TX_THRESH_OFS    = 8'h1C;
  localparam logic [7:0] CFG_OFS          = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FC_FIFO_EN   = 0;
  localparam int FC_RX_RESET  = 1;
  localparam int FC_TX_RESET  = 2;
  localparam int FC_DMA_MODE  = 3;
  localparam int FC_TRIG_LO   = 6;
  localparam int FC_TRIG_HI   = 7;
  localparam int CFG_AUTO_FC  = 0;
  localparam int CFG_EXT_HS   = 1;
  localparam int IRQ_RX_AVAIL = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_RX_OVR   = 2;
  localparam int IRQ_W        = 3;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          DATA_W        = 8;
  localparam int          DEPTH         = 16;
  localparam int          PTR_W         = 4;
  localparam int          CNT_W         = 5;
  localparam logic [7:0]  FC_RESET      = 8'h00;
  localparam logic [4:0]  TX_THRESH_RST = 5'h00;
  localparam logic [1:0]  CFG_RESET     = 2'h0;
  localparam logic [2:0]  MASK_RESET    = 3'h0;

  // Trigger levels: one char, quarter, half, two short of full
  localparam logic [4:0] TRIG_ONE     = 5'h01;
  localparam logic [4:0] TRIG_QUARTER = 5'h04;
  localparam logic [4:0] TRIG_HALF    = 5'h08;
  localparam logic [4:0] TRIG_ALMOST  = 5'h0E;

  // Settling time after a reset or enable change
  localparam int SETTLE_CYC = 8;
  localparam logic [3:0] SETTLE_CNT = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_BURST = 2'b10
  } ufc_burst_type;

endpackage : ufc_pkg

// ---- logic/ufc_fifo_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module ufc_fifo_mem (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_clear,
  input  wire logic                         i_push,
  input  wire logic [ufc_pkg::DATA_W-1:0]   i_data,
  input  wire logic                         i_pop,
  output logic      [ufc_pkg::DATA_W-1:0]   o_data,
  output logic      [ufc_pkg::CNT_W-1:0]    o_count
);
  import ufc_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]  wr_ptr;
  logic [PTR_W-1:0]  rd_ptr;
  wire               do_push = i_push && (o_count != CNT_W'(DEPTH));
  wire               do_pop  = i_pop && (o_count != '0);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_clear) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      o_count <= '0;
      o_data  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
        o_data <= mem[rd_ptr];
      end
      o_count <= o_count + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end
endmodule : ufc_fifo_mem
`default_nettype wire

// ---- tb/ufc_fifo_ctrl_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module ufc_fifo_ctrl_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq,
  input wire logic        i_tx_wr,
  input wire logic        i_tx_pop,
  input wire logic        i_rx_push,
  input wire logic        i_rx_rd,
  input wire logic        o_rts_n,
  input wire logic        o_dma_tx_req_n,
  input wire logic        o_dma_rx_req_n,
  input wire logic        o_fifo_busy
);
  import ufc_pkg::*;
  logic auto_q;
  logic burst_q;
  logic en_q;
  wire  fc_wr = i_wr && (i_addr == FIFO_CONTROL_OFS);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      auto_q  <= 1'b0;
      burst_q <= 1'b0;
      en_q    <= 1'b0;
    end else begin
      if (i_wr && (i_addr == CFG_OFS)) auto_q <= i_wdata[CFG_AUTO_FC];
      if (fc_wr) burst_q <= i_wdata[FC_DMA_MODE];
      if (fc_wr) en_q <= i_wdata[FC_FIFO_EN];
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_rdata_idle_zero: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside read slot");
  a_ctrl_reads_zero: assert property (
    i_rd && i_addr == FIFO_CONTROL_OFS |=> o_rdata == 32'h0) else $error("control read not zero");
  a_busy_window: assert property (
    fc_wr && (i_wdata[FC_TX_RESET] || i_wdata[FC_RX_RESET] || i_wdata[FC_FIFO_EN] != en_q)
    |=> o_fifo_busy [*8]) else $error("busy window too short");
  a_busy_ends: assert property (
    $rose(o_fifo_busy) |-> ##[8:9] !o_fifo_busy) else $error("busy window too long");
  a_rts_manual: assert property (
    !auto_q && !$past(auto_q) |-> !o_rts_n) else $error("rts high without flow control");
  a_rx_clear_idle: assert property (
    fc_wr && i_wdata[FC_RX_RESET] && !i_rx_push |-> ##[1:3] o_dma_rx_req_n)
    else $error("rx request after rx clear");
  a_tx_clear_req: assert property (
    fc_wr && i_wdata[FC_TX_RESET] && !i_tx_wr |-> ##[1:3] !o_dma_tx_req_n)
    else $error("no tx request after tx clear");
  a_tx_single_drop: assert property (
    i_tx_wr && !burst_q && !i_tx_pop && !o_fifo_busy |-> ##[1:2] o_dma_tx_req_n)
    else $error("tx request kept after one char");
  a_rx_single_req: assert property (
    i_rx_push && !burst_q && !i_rx_rd && !o_fifo_busy |-> ##[1:2] !o_dma_rx_req_n)
    else $error("no rx request for one char");
  c_burst_mode: cover property (fc_wr && i_wdata[FC_DMA_MODE]);
  c_irq_seen: cover property (o_irq);
  c_burst_tx_req: cover property ($fell(o_dma_tx_req_n) && burst_q);
endmodule : ufc_fifo_ctrl_chk
bind ufc_fifo_ctrl ufc_fifo_ctrl_chk u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_tx_wr(i_tx_wr),
  .i_tx_pop(i_tx_pop), .i_rx_push(i_rx_push), .i_rx_rd(i_rx_rd), .o_rts_n(o_rts_n),
  .o_dma_tx_req_n(o_dma_tx_req_n), .o_dma_rx_req_n(o_dma_rx_req_n),
  .o_fifo_busy(o_fifo_busy)
);
`default_nettype wire

// ---- tb/ufc_dma_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ufc_dma_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tx_en,
  input  wire logic       i_rx_en,
  input  wire logic       i_slow,
  input  wire logic       i_burst,
  input  wire logic       i_dma_tx_req_n,
  input  wire logic       i_dma_rx_req_n,
  output logic            o_tx_wr,
  output logic      [7:0] o_tx_data,
  output logic            o_rx_rd,
  output logic      [7:0] o_tx_sent,
  output logic      [7:0] o_rx_taken
);
  logic [1:0] tx_gap;
  logic [1:0] rx_gap;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tx_wr    <= 1'b0;
      o_rx_rd    <= 1'b0;
      o_tx_data  <= 8'h00;
      o_tx_sent  <= 8'h00;
      o_rx_taken <= 8'h00;
      tx_gap     <= 2'h0;
      rx_gap     <= 2'h0;
    end else begin
      o_tx_wr   <= 1'b0;
      o_rx_rd   <= 1'b0;
      o_tx_data <= ~o_tx_data;
      if (tx_gap != 2'h0) begin
        tx_gap <= tx_gap - 2'h1;
      end else if (i_tx_en && !i_dma_tx_req_n) begin
        o_tx_wr   <= 1'b1;
        o_tx_data <= 8'h40 + o_tx_sent;
        o_tx_sent <= o_tx_sent + 8'h1;
        tx_gap    <= i_slow ? 2'h3 : (i_burst ? 2'h0 : 2'h2);
      end
      if (rx_gap != 2'h0) begin
        rx_gap <= rx_gap - 2'h1;
      end else if (i_rx_en && !i_dma_rx_req_n) begin
        o_rx_rd    <= 1'b1;
        o_rx_taken <= o_rx_taken + 8'h1;
        rx_gap     <= 2'h2;
      end
    end
  end
endmodule : ufc_dma_model
`default_nettype wire

// ---- tb/ufc_fifo_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module ufc_fifo_ctrl_tb;
  import ufc_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        i_core_clk, i_rst, i_wr, i_rd, i_tx_pop, i_rx_push;
  logic        tx_en, rx_en, slow, burst;
  logic [7:0]  i_addr, i_rx_data, o_tx_data, o_rx_data, tx_data, tx_sent, rx_taken, s0;
  logic [31:0] i_wdata, o_rdata;
  logic        o_irq, o_rts_n, o_dma_tx_req_n, o_dma_rx_req_n, o_fifo_busy, tx_wr, rx_rd;
  logic [4:0]  lv [4];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          c;
  int          k;
  ufc_fifo_ctrl dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_tx_wr(tx_wr),
    .i_tx_data(tx_data), .i_tx_pop(i_tx_pop), .o_tx_data(o_tx_data),
    .i_rx_push(i_rx_push), .i_rx_data(i_rx_data), .i_rx_rd(rx_rd), .o_rx_data(o_rx_data),
    .o_rts_n(o_rts_n), .o_dma_tx_req_n(o_dma_tx_req_n), .o_dma_rx_req_n(o_dma_rx_req_n),
    .o_fifo_busy(o_fifo_busy));
  ufc_dma_model u_dma (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_tx_en(tx_en), .i_rx_en(rx_en),
    .i_slow(slow), .i_burst(burst), .i_dma_tx_req_n(o_dma_tx_req_n),
    .i_dma_rx_req_n(o_dma_rx_req_n), .o_tx_wr(tx_wr), .o_tx_data(tx_data),
    .o_rx_rd(rx_rd), .o_tx_sent(tx_sent), .o_rx_taken(rx_taken));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    @(negedge i_core_clk);
    check(o_rdata & m, e);
  endtask : rd
  task automatic push(input logic [7:0] d);
    @(posedge i_core_clk);
    i_rx_push <= 1'b1;
    i_rx_data <= d;
    @(posedge i_core_clk);
    i_rx_push <= 1'b0;
  endtask : push
  task automatic pop(input logic [7:0] e);
    @(posedge i_core_clk);
    i_tx_pop <= 1'b1;
    @(posedge i_core_clk);
    i_tx_pop <= 1'b0;
    @(negedge i_core_clk);
    check({24'h0, o_tx_data}, {24'h0, e});
  endtask : pop
  task automatic settle();
    int j;
    idle(2);
    for (j = 0; j < 20 && o_fifo_busy !== 1'b0; j++) idle(0);
    check({31'h0, o_fifo_busy}, 32'h0);
  endtask : settle
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    lv = '{TRIG_ONE, TRIG_QUARTER, TRIG_HALF, TRIG_ALMOST};
    {i_wr, i_rd, i_tx_pop, i_rx_push, tx_en, rx_en, slow, burst} = 8'h00;
    {i_addr, i_rx_data, i_wdata} = 48'h0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(FIFO_CONTROL_OFS, ALL, 32'h0);
    wr(8'h04, ALL);
    rd(8'h04, ALL, 32'h0);
    rd(MASK_OFS, ALL, {29'h0, MASK_RESET});
    rd(TX_THRESH_OFS, ALL, {27'h0, TX_THRESH_RST});
    $display("test registers done");
    wr(FIFO_CONTROL_OFS, 32'h01);
    settle();
    wr(CFG_OFS, 32'h1);
    wr(MASK_OFS, 32'h1);
    for (c = 0; c < 4; c++) begin
      wr(FIFO_CONTROL_OFS, {24'h0, c[1:0], 6'h03});
      settle();
      wr(STATUS_OFS, 32'h7);
      for (k = 1; k < int'(lv[c]); k++) push(8'h20);
      idle(3);
      check({30'h0, o_rts_n, o_irq}, 32'h0);
      push(8'h21);
      idle(3);
      check({30'h0, o_rts_n, o_irq}, 32'h3);
    end
    rd(STATUS_OFS, 32'h1, 32'h1);
    wr(MASK_OFS, 32'h0);
    idle(2);
    check({31'h0, o_irq}, 32'h0);
    wr(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, 32'h1, 32'h0);
    wr(FIFO_CONTROL_OFS, 32'h0);
    settle();
    rd(FILL_OFS, ALL, 32'h0);
    wr(CFG_OFS, 32'h0);
    $display("test trigger levels done");
    wr(FIFO_CONTROL_OFS, 32'h49);
    settle();
    s0 = rx_taken;
    for (k = 0; k < 3; k++) push(8'h30);
    idle(3);
    check({31'h0, o_dma_rx_req_n}, 32'h1);
    rx_en <= 1'b1;
    push(8'h33);
    idle(30);
    check({24'h0, rx_taken - s0}, 32'h4);
    check({24'h0, o_rx_data}, 32'h33);
    check({31'h0, o_dma_rx_req_n}, 32'h1);
    rx_en <= 1'b0;
    $display("test rx burst done");
    wr(FIFO_CONTROL_OFS, 32'h05);
    settle();
    s0 = tx_sent;
    slow  <= 1'b1;
    tx_en <= 1'b1;
    idle(20);
    rd(FILL_OFS, 32'h1F, 32'h1);
    pop(8'h40 + s0);
    idle(20);
    check({24'h0, tx_sent - s0}, 32'h2);
    tx_en <= 1'b0;
    $display("test tx single done");
    wr(FIFO_CONTROL_OFS, 32'h0D);
    settle();
    s0 = tx_sent;
    slow  <= 1'b0;
    burst <= 1'b1;
    tx_en <= 1'b1;
    idle(40);
    rd(FILL_OFS, 32'h1F, 32'(DEPTH));
    check({31'h0, o_dma_tx_req_n}, 32'h1);
    tx_en <= 1'b0;
    for (k = 0; k < DEPTH; k++) pop(8'h40 + s0 + k[7:0]);
    idle(3);
    check({31'h0, o_dma_tx_req_n}, 32'h0);
    $display("test tx burst done");
    wr(FIFO_CONTROL_OFS, 32'h00);
    settle();
    check({31'h0, o_dma_tx_req_n}, 32'h0);
    s0 = tx_sent;
    slow  <= 1'b1;
    burst <= 1'b0;
    tx_en <= 1'b1;
    idle(10);
    tx_en <= 1'b0;
    check({24'h0, tx_sent - s0}, 32'h1);
    pop(8'h40 + s0);
    idle(3);
    check({31'h0, o_dma_tx_req_n}, 32'h0);
    $display("test holding register done");
    report_and_stop();
  end
endmodule : ufc_fifo_ctrl_tb
`default_nettype wire
